// file: rtl/nbe_top.sv
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module nbe_top (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [13:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic controller_busy_flag,
  input wire nbe_pkg::nbe_eng_t eng_i,
  output logic [31:0] eng_rdata,
  input wire nbe_pkg::nbe_nand_t nand_i,
  output logic irq
);
  import nbe_pkg::*;

  nbe_state_t s, n;
  logic [31:0] mem [0:BUF_WORDS-1];
  logic [31:0] host_q;
  logic hit, in_buf, eng_own, host_drop, hwr, swrst, start, bw;
  logic [12:0] ephys, mainw;
  logic [11:0] mainm, secm, lidx;
  logic [31:0] fa, syn, shn, sr1, sr2;
  logic [2:0] sbn;
  nbe_gran_t gr;

  // ----------------------------------------------------------------
  // parity folding
  // ----------------------------------------------------------------
  // code layout {P[15:0], P'[15:0]}; bit k of the position vector
  // {word index, bit in word} decides P[k] or P'[k]
  function automatic logic [31:0] fold(input logic [15:0] w,
      input logic [11:0] idx, input logic b16, input logic [31:0] acc);
    logic [15:0] f;
    logic [31:0] r;
    r = acc;
    for (int b = 0; b < 16; b++) begin
      f = b16 ? {idx, 4'(b)} : {1'b0, idx, 3'(b)};
      if (w[b] && (b16 || b < 8)) begin
        r = r ^ {f, ~f};
      end
    end
    return r;
  endfunction

  always_comb begin
    sr1 = '0;
    sr2 = '0;
    for (int k = 0; k < 8; k++) begin
      sr1[k*FLAG_NIB +: 3] = s.flag[k];
      sr2[k*FLAG_NIB +: 3] = s.flag[k+8];
    end
  end

  // ----------------------------------------------------------------
  // buffer ownership and bank mapping
  // ----------------------------------------------------------------
  assign eng_own = controller_busy_flag | eng_i.req;
  // bank select only applies up to 2 KB pages; 4 KB pages fill bank 0
  assign ephys = eng_i.addr +
      ((s.bank && s.cfg.ps != PS4096) ? BANK1_BASE : '0);
  assign hit = cyc_i & stb_i & ~s.ack;
  assign in_buf = ~adr_i[13];
  assign host_drop = hit & in_buf & eng_own;
  assign hwr = hit & in_buf & ~eng_own & we_i &
      (adr_i[12:0] < BUF_END);

  always_ff @(posedge mclk) begin
    if (eng_i.req) begin
      if (eng_i.we) begin
        mem[ephys[12:2]] <= eng_i.wdata;
      end
      eng_rdata <= mem[ephys[12:2]];
    end
    if (hwr) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          mem[adr_i[12:2]][b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
    end
    host_q <= mem[adr_i[12:2]];
  end

  // ----------------------------------------------------------------
  // ecc geometry
  // ----------------------------------------------------------------
  assign bw = s.cfg.bus16;
  assign gr = bw ? GR_PAGE : s.cfg.gran;
  assign mainw = (MAIN_MIN << s.cfg.ps) >> bw;
  assign mainm = 12'(mainw - 13'h1);
  assign secm = (gr == GR_256) ? SEC256_M :
      (gr == GR_512) ? SEC512_M : mainm;
  assign lidx = s.wcnt & secm;
  assign fa = fold(nand_i.io, lidx, bw, s.acc);
  assign shn = bw ? {s.sh[15:0], nand_i.io} : {s.sh[23:0], nand_i.io[7:0]};
  assign sbn = s.sb + (bw ? 3'h2 : 3'h1);
  assign syn = s.code[s.chk[3:0]] ^ shn;
  assign start = nand_i.cmd_stb &
      (nand_i.io[7:0] == CMD_READ || nand_i.io[7:0] == CMD_PROG);
  assign swrst = hit & we_i & (adr_i == REG_ECC_CTRL) & dat_i[CTRL_SWRST];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.ack = hit;
    if (hit) begin
      n.hbuf = in_buf;
      n.hres = (adr_i[12:0] >= BUF_END) | host_drop;
    end
    if (hit & ~in_buf) begin
      n.rdata = '0;
      if (adr_i >= REG_PR0 && adr_i < REG_PR_END) begin
        n.rdata = s.code[adr_i[5:2]];
      end else begin
        case (adr_i)
          REG_CFG: n.rdata = {{(32-CFG_W){1'b0}}, s.cfg};
          REG_STAT: n.rdata = {30'h0, s.viol, controller_busy_flag};
          REG_BANK: n.rdata = {31'h0, s.bank};
          REG_SR1: n.rdata = sr1;
          REG_SR2: n.rdata = sr2;
          REG_IE: n.rdata = {30'h0, s.ie};
          default: n.rdata = '0;
        endcase
      end
      if (we_i) begin
        case (adr_i)
          REG_CFG: n.cfg = nbe_cfg_t'(dat_i[CFG_W-1:0]);
          REG_BANK: n.bank = dat_i[0];
          REG_IE: n.ie = dat_i[1:0];
          REG_STAT: begin
            if (dat_i[STAT_VIOL]) begin
              n.viol = 1'b0;
            end
          end
          default: n.ie = n.ie;
        endcase
      end
    end
    if (host_drop) begin
      n.viol = 1'b1;
    end
    if (start | swrst) begin
      n.code = '0;
      n.flag = '0;
      n.acc = '0;
      n.sec = '0;
      n.chk = '0;
      n.sb = '0;
      n.wcnt = '0;
      n.wr = (nand_i.io[7:0] == CMD_PROG);
      n.est = swrst ? ST_IDLE : ST_ARMED;
    end else begin
      case (s.est)
        ST_ARMED: begin
          if (nand_i.addr_stb) begin
            n.est = ST_MAIN;
          end
        end
        ST_MAIN: begin
          if (nand_i.addr_stb) begin
            n.wcnt = '0;
          end else if (nand_i.data_stb) begin
            n.acc = fa;
            if (lidx == secm) begin
              n.code[s.sec[3:0]] = fa;
              n.acc = '0;
              n.sec = s.sec + 5'h1;
            end
            n.wcnt = s.wcnt + 12'h1;
            if (s.wcnt == mainm) begin
              n.est = s.wr ? ST_IDLE : ST_SPARE;
            end
          end
        end
        ST_SPARE: begin
          if (nand_i.data_stb) begin
            n.sh = shn;
            n.sb = sbn;
            if (sbn == CODE_BYTES) begin
              n.sb = '0;
              n.chk = s.chk + 5'h1;
              if (syn == '0) begin
                n.flag[s.chk[3:0]] = '0;
              end else if ((syn[31:16] ^ syn[15:0]) == 16'hffff) begin
                n.flag[s.chk[3:0]] = FL_REC;
                n.code[s.chk[3:0]] = bw ?
                    {12'h0, syn[19:16], 4'h0, syn[31:20]} :
                    {12'h0, 1'b0, syn[18:16], 4'h0, syn[30:19]};
              end else if ($countones(syn) == 1) begin
                n.flag[s.chk[3:0]] = FL_ECC;
              end else begin
                n.flag[s.chk[3:0]] = FL_MUL;
              end
              if (s.chk + 5'h1 == s.sec) begin
                n.est = ST_IDLE;
              end
            end
          end
        end
        default: n.est = s.est;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign ack_o = s.ack;
  // dropped or reserved reads return zero, which software must not trust
  assign dat_o = !s.ack ? '0 : !s.hbuf ? s.rdata :
      s.hres ? '0 : host_q;
  assign irq = (s.ie[IE_VIOL] & s.viol) |
      (s.ie[IE_ECC] & (|s.flag));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // bus side: one-cycle ack, dropped and reserved reads return zero
  AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not acknowledged next cycle");
  AST_ACK_DROP: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  AST_VIOL_SET: assert property (host_drop |=> s.viol)
    else $error("dropped access did not raise violation");
  AST_VIOL_CLR: assert property (
      hit && !in_buf && we_i && adr_i == REG_STAT && dat_i[STAT_VIOL]
      |=> !s.viol)
    else $error("violation flag not cleared by write one");
  AST_NO_WR_BUSY: assert property (
      cyc_i && stb_i && we_i && in_buf && controller_busy_flag |-> !hwr)
    else $error("host write reached buffer while engine owns it");
  AST_DROP_RD: assert property (host_drop |=> dat_o == '0)
    else $error("dropped read returned buffer data");
  AST_RSVD_RD: assert property (
      hit && in_buf && adr_i[12:0] >= BUF_END |=> dat_o == '0)
    else $error("reserved buffer offset returned data");
  AST_BANK1: assert property (
      s.bank && s.cfg.ps != PS4096 |-> ephys == eng_i.addr + BANK1_BASE)
    else $error("bank 1 engine access not moved to its base");
  AST_BANK4K: assert property (
      s.cfg.ps == PS4096 |-> ephys == eng_i.addr)
    else $error("4 KB page used bank offset");

  // ecc side: clearing, locking and classification of each code
  AST_CLEAR: assert property (
      start |=> s.flag == '0 && s.code == '0 && s.est == ST_ARMED)
    else $error("page command did not clear ecc results");
  AST_SWRST: assert property (
      swrst |=> s.flag == '0 && s.code == '0 && s.est == ST_IDLE)
    else $error("software reset did not clear ecc results");
  AST_ARM: assert property (
      start && !swrst |=> s.wr == ($past(nand_i.io[7:0]) == CMD_PROG))
    else $error("page command direction not captured");
  AST_ADDR: assert property (
      s.est == ST_ARMED && nand_i.addr_stb && !start && !swrst
      |=> s.est == ST_MAIN && s.wcnt == '0)
    else $error("address cycle did not start counting");
  AST_LOCK: assert property (
      s.est == ST_IDLE && !start && !swrst
      |=> $stable(s.code) && $stable(s.flag))
    else $error("parity results changed while locked");
  AST_MAIN_END: assert property (
      s.est == ST_MAIN && nand_i.data_stb && !nand_i.addr_stb
      && s.wcnt == mainm && !start && !swrst |=> s.est != ST_MAIN)
    else $error("main area end not detected");
  AST_SEC_CNT: assert property (
      s.est == ST_MAIN && nand_i.data_stb && !nand_i.addr_stb
      && lidx == secm && !start && !swrst |=> s.sec == $past(s.sec) + 5'h1)
    else $error("sector end did not advance the code index");
  AST_GRAN16: assert property (s.cfg.bus16 |-> secm == mainm)
    else $error("16-bit device used a per-sector code");

  // a stored code is complete at its last byte or word
  logic code_done;
  assign code_done = s.est == ST_SPARE && nand_i.data_stb &&
      sbn == CODE_BYTES && !start && !swrst;
  AST_NOERR: assert property (
      code_done && syn == '0 |=> s.flag[$past(s.chk[3:0])] == '0)
    else $error("zero syndrome reported an error");
  AST_REC: assert property (
      code_done && (syn[31:16] ^ syn[15:0]) == 16'hffff
      |=> s.flag[$past(s.chk[3:0])] == FL_REC)
    else $error("single data error not flagged correctable");
  AST_ECC: assert property (
      code_done && (syn[31:16] ^ syn[15:0]) != 16'hffff
      && $countones(syn) == 1 |=> s.flag[$past(s.chk[3:0])] == FL_ECC)
    else $error("stored code error not flagged");
  AST_MUL: assert property (
      code_done && (syn[31:16] ^ syn[15:0]) != 16'hffff
      && $countones(syn) > 1 |=> s.flag[$past(s.chk[3:0])] == FL_MUL)
    else $error("multiple errors not flagged");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  COV_VIOL: cover property (host_drop ##1 s.viol);
  COV_REC: cover property (start ##[1:1000] s.flag[0] == FL_REC);
  COV_MUL: cover property (start ##[1:1000] s.flag[0] == FL_MUL);
  COV_ECC: cover property (start ##[1:1000] s.flag[0] == FL_ECC);
  COV_WRITE_LOCK: cover property (s.est == ST_MAIN && s.wr
      ##1 s.est == ST_IDLE);

endmodule
`default_nettype wire

// file: rtl/nbe_pkg.sv
package nbe_pkg;

  // ----------------------------------------------------------------
  // page buffer
  // ----------------------------------------------------------------
  localparam int BUF_WORDS = 1056;
  localparam logic [12:0] BUF_END = 13'h1080;
  localparam logic [12:0] BANK1_BASE = 13'h0840;

  // ----------------------------------------------------------------
  // register byte addresses (buffer occupies 0x0000-0x1fff)
  // ----------------------------------------------------------------
  localparam logic [13:0] REG_CFG = 14'h2000;
  localparam logic [13:0] REG_STAT = 14'h2004;
  localparam logic [13:0] REG_BANK = 14'h2008;
  localparam logic [13:0] REG_ECC_CTRL = 14'h200c;
  localparam logic [13:0] REG_SR1 = 14'h2010;
  localparam logic [13:0] REG_SR2 = 14'h2014;
  localparam logic [13:0] REG_IE = 14'h2018;
  localparam logic [13:0] REG_PR0 = 14'h2040;
  localparam logic [13:0] REG_PR_END = 14'h2080;

  localparam int STAT_BUSY = 0;
  localparam int STAT_VIOL = 1;
  localparam int CTRL_SWRST = 0;
  localparam int IE_VIOL = 0;
  localparam int IE_ECC = 1;
  localparam int FLAG_NIB = 4;

  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [2:0] FL_REC = 3'h1;
  localparam logic [2:0] FL_ECC = 3'h2;
  localparam logic [2:0] FL_MUL = 3'h4;
  localparam logic [2:0] CODE_BYTES = 3'h4;
  localparam logic [12:0] MAIN_MIN = 13'h0200;
  localparam logic [11:0] SEC256_M = 12'h0ff;
  localparam logic [11:0] SEC512_M = 12'h1ff;

  typedef enum logic [1:0] {
    PS512 = 2'h0, PS1024 = 2'h1, PS2048 = 2'h2, PS4096 = 2'h3
  } nbe_ps_t;

  typedef enum logic [1:0] {
    GR_PAGE = 2'h0, GR_256 = 2'h1, GR_512 = 2'h2
  } nbe_gran_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ARMED = 2'b01, ST_MAIN = 2'b11, ST_SPARE = 2'b10
  } nbe_est_t;

  typedef struct packed {
    logic bus16;
    nbe_gran_t gran;
    nbe_ps_t ps;
  } nbe_cfg_t;
  localparam int CFG_W = 5;

  typedef struct packed {
    logic req;
    logic we;
    logic [12:0] addr;
    logic [31:0] wdata;
  } nbe_eng_t;

  typedef struct packed {
    logic cmd_stb;
    logic addr_stb;
    logic data_stb;
    logic [15:0] io;
  } nbe_nand_t;

  typedef struct packed {
    nbe_cfg_t cfg;
    logic bank;
    logic viol;
    logic [1:0] ie;
    logic ack;
    logic hbuf;
    logic hres;
    logic [31:0] rdata;
    nbe_est_t est;
    logic wr;
    logic [11:0] wcnt;
    logic [4:0] sec;
    logic [4:0] chk;
    logic [2:0] sb;
    logic [31:0] sh;
    logic [31:0] acc;
    logic [15:0][31:0] code;
    logic [15:0][2:0] flag;
  } nbe_state_t;

endpackage

// file: tb/nbe_nand_model.sv
`timescale 1ns/1ns
`default_nettype none
module nbe_nand_model (
  input wire logic mclk,
  output nbe_pkg::nbe_nand_t nand_o
);
  import nbe_pkg::*;

  initial nand_o = '0;

  task automatic strobe(input logic [2:0] s, input logic [7:0] b);
    @(posedge mclk);
    nand_o <= {s, 8'h00, b};
  endtask

  // ----------------------------------------------------------------
  // one page: command, address, main bytes, then stored code on read
  // ----------------------------------------------------------------
  // always from offset 0 and without gaps
  // the stored code is the code argument, chosen by the caller
  task automatic page(input logic [7:0] cmd, input int e1, input int e2,
                      input logic [31:0] code);
    strobe(3'b100, cmd);
    strobe(3'b010, 8'h00);
    for (int i = 0; i < 512; i++) begin
      strobe(3'b001, (i == e1 || i == e2) ? 8'h08 : 8'h00);
    end
    if (cmd == CMD_READ) begin
      for (int k = 3; k >= 0; k--) begin
        strobe(3'b001, code[k*8 +: 8]);
      end
    end
    // released bus shows the inverse, so a stale value never passes
    @(posedge mclk);
    nand_o <= {3'b000, ~nand_o.io};
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import nbe_pkg::*;
  logic mclk, rstn, cyc_i, stb_i, we_i, ack_o, irq, busy;
  logic [13:0] adr_i;
  logic [31:0] dat_i, dat_o, eng_rdata, q;
  logic [3:0] sel_i;
  nbe_eng_t eng_i;
  nbe_nand_t nand_i;
  int n_fail, samples_checked;
  int e1s[4] = '{-1, 5, -1, 5};
  int e2s[4] = '{-1, -1, -1, 6};
  logic [31:0] codes[4] = '{32'h0, 32'h0, 32'h1, 32'h0};
  logic [2:0] fls[4] = '{3'h0, FL_REC, FL_ECC, FL_MUL};

  nbe_top dut_u (.mclk(mclk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .controller_busy_flag(busy),
    .eng_i(eng_i), .eng_rdata(eng_rdata), .nand_i(nand_i), .irq(irq));
  nbe_nand_model nand_u (.mclk(mclk), .nand_o(nand_i));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request stands until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [13:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge mclk);
    while (ack_o !== 1'b1 && n < 16) begin
      @(posedge mclk);
      n++;
    end
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 16) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    wb(1'b1, a, d, q);
  endtask

  task automatic eng(input logic w, input logic [12:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    eng_i <= '{req: 1'b1, we: w, addr: a, wdata: d};
    @(posedge mclk);
    eng_i <= '0;
    @(negedge mclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    {cyc_i, stb_i, we_i, busy} = 4'h0;
    adr_i = 14'h0;
    dat_i = 32'h0;
    sel_i = 4'hf;
    eng_i = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rd(REG_CFG, 32'h0);
    rd(REG_STAT, 32'h0);
    rd(REG_SR1, 32'h0);
    rd(REG_PR0, 32'h0);
    $display("test reset done");

    wr(REG_CFG, 32'h3);
    wr(14'h0010, 32'h1234abcd);
    sel_i <= 4'h1;
    wr(14'h0010, 32'hffffffff);
    sel_i <= 4'hf;
    rd(14'h0010, 32'h1234abff);
    wr(14'h107c, 32'h5a5a0f0f);
    rd(14'h107c, 32'h5a5a0f0f);
    wr(14'h1080, 32'hffffffff);
    rd(14'h1080, 32'h0);
    rd(14'h2020, 32'h0);
    $display("test memory done");

    wr(REG_CFG, 32'h2);
    wr(REG_BANK, 32'h1);
    wr(14'h0848, 32'hcafe0001);
    eng(1'b0, 13'h0008, 32'h0);
    chk(eng_rdata, 32'hcafe0001);
    eng(1'b1, 13'h0000, 32'h600d0002);
    rd(14'h0840, 32'h600d0002);
    $display("test bank done");

    busy <= 1'b1;
    wr(14'h0010, 32'h0);
    rd(14'h0010, 32'h0);
    rd(REG_STAT, 32'h3);
    busy <= 1'b0;
    rd(14'h0010, 32'h1234abff);
    wr(REG_IE, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(REG_STAT, 32'h2);
    rd(REG_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test violation done");

    // 512-byte page, one code per page, 8-bit bus
    wr(REG_CFG, 32'h0);
    wr(REG_IE, 32'h2);
    nand_u.page(CMD_PROG, 5, -1, 32'h0);
    rd(REG_PR0, 32'h002bffd4);
    for (int c = 0; c < 4; c++) begin
      nand_u.page(CMD_READ, e1s[c], e2s[c], codes[c]);
      rd(REG_SR1, {29'h0, fls[c]});
      if (c == 1) begin
        rd(REG_PR0, 32'h00030005);
      end
    end
    chk({31'h0, irq}, 32'h1);
    wr(REG_ECC_CTRL, 32'h1);
    rd(REG_SR1, 32'h0);
    rd(REG_PR0, 32'h0);
    $display("test ecc done");

    // per-256 codes on an 8-bit page, then a 16-bit page forcing one code
    wr(REG_CFG, 32'h4);
    nand_u.page(CMD_PROG, 5, 261, 32'h0);
    rd(REG_PR0, 32'h002bffd4);
    rd(REG_PR0 + 14'h4, 32'h002bffd4);
    wr(REG_CFG, 32'h14);
    nand_u.page(CMD_PROG, 5, 261, 32'h0);
    rd(REG_PR0, 32'h0053ffac);
    rd(REG_PR0 + 14'h4, 32'h0);
    $display("test granularity done");
    end_of_test();
  end
endmodule
`default_nettype wire
